//--- rtl/ptmr_consts.svh
`ifndef PTMR_CONSTS_SVH
`define PTMR_CONSTS_SVH
// register byte addresses
`define PTMR_ADDR_CTRL0   8'h00
`define PTMR_ADDR_CTRL1   8'h04
`define PTMR_ADDR_CNT_LO  8'h08
`define PTMR_ADDR_CNT_HI  8'h0C
`define PTMR_ADDR_DUTY_LO 8'h10
`define PTMR_ADDR_DUTY_HI 8'h14
`define PTMR_ADDR_PER_LO  8'h18
`define PTMR_ADDR_PER_HI  8'h1C
`define PTMR_ADDR_FLAGS   8'h20
// flags register bit positions
`define PTMR_FLAG_A 0
`define PTMR_FLAG_P 1
// axi response codes
`define PTMR_RESP_OKAY   2'b00
`define PTMR_RESP_SLVERR 2'b10
// clock select codes
`define PTMR_CK_SYS4  3'h0
`define PTMR_CK_SYS   3'h1
`define PTMR_CK_H16   3'h2
`define PTMR_CK_H64   3'h3
`define PTMR_CK_TBC   3'h4
`define PTMR_CK_H     3'h5
`define PTMR_CK_EXT_R 3'h6
`define PTMR_CK_EXT_F 3'h7
// prescaler taps
`define PTMR_DIV4_MASK  6'h03
`define PTMR_DIV16_MASK 6'h0F
`define PTMR_DIV64_MASK 6'h3F
`define PTMR_CNT_MAX 10'h3FF
`define PTMR_CNT_ZERO 10'h000
`endif

//--- rtl/ptmr_pkg.sv
package ptmr_pkg;
  // operating mode field
  typedef enum logic [1:0] {
    PTMR_MODE_CMP  = 2'h0,
    PTMR_MODE_CAP  = 2'h1,
    PTMR_MODE_PWM  = 2'h2,
    PTMR_MODE_TMR  = 2'h3
  } ptmr_mode_e;
  // control register zero
  typedef struct packed {
    logic       pause_bit;
    logic [2:0] clock_select_field;
    logic       counter_enable_bit;
  } ptmr_ctrl0_s;
  // control register one
  typedef struct packed {
    ptmr_mode_e mode_field;
    logic [1:0] output_action;
    logic       initial_level_bit;
    logic       output_polarity_bit;
    logic       capture_source_select;
    logic       clear_select_bit;
  } ptmr_ctrl1_s;
  // single pulse state machine
  typedef enum logic [1:0] {
    PTMR_SP_IDLE = 2'b01,
    PTMR_SP_RUN  = 2'b10
  } ptmr_sp_e;
endpackage

//--- rtl/ptmr_timer.sv
// The address map and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
`include "ptmr_consts.svh"
module ptmr_timer
  import ptmr_pkg::*;
#(
  parameter int CW = 10
) (
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  input  wire logic        tick_tbc_i,
  input  wire logic        tick_h_i,
  input  wire logic        external_clock_input_pin_i,
  input  wire logic        timer_output_pin_i,
  output logic             timer_output_pin_o,
  output logic             timer_output_pin_oe_o
);
  ptmr_ctrl0_s     ctrl0;         // pause, clock, enable
  ptmr_ctrl1_s     ctrl1;         // mode and output control
  logic [CW-1:0]   count;         // running counter
  logic [CW-1:0]   duty;          // duty compare value
  logic [CW-1:0]   period;        // period compare value
  logic            flag_a;        // comparator a flag
  logic            flag_p;        // comparator p flag
  logic            cmp_out;       // compare output level
  ptmr_sp_e        sp_state;      // single pulse state
  logic            en_q;          // previous enable
  logic [5:0]      presc;         // internal prescaler
  logic [2:0]      ext_sync;      // clock pin synchroniser
  logic [2:0]      tp_sync;       // output pin synchroniser
  logic            ext_lvl;       // filtered clock pin
  logic            tp_lvl;        // filtered output pin
  logic            ext_rise;      // clock pin rising
  logic            ext_fall;      // clock pin falling
  logic            tp_rise;       // output pin rising
  logic            tp_fall;       // output pin falling
  logic            tick;          // count clock tick
  logic            match_a;       // comparator a match
  logic            match_p;       // comparator p match
  logic            ovf;           // counter overflow
  logic            clr_cnt;       // counter clear
  logic            set_a;         // flag a event
  logic            set_p;         // flag p event
  logic            en_rise;       // enable rising edge
  logic            cap_ev;        // capture event
  logic            sp_trig;       // single pulse pin trigger
  logic            sp_stop;       // single pulse end
  logic            aw_hold;       // write address held
  logic            w_hold;        // write data held
  logic [7:0]      aw_addr;       // stored write address
  logic [31:0]     w_data;        // stored write data
  logic [3:0]      w_strb;        // stored write strobes
  logic            do_write;      // write commits now
  logic            wr_ctrl0;      // control zero written
  logic [31:0]     next_rdata;    // read mux
  logic            next_rerr;     // unmapped read
  logic            pwm_raw;       // pwm active phase
  logic            out_act;       // output before polarity
  logic [CW:0]     per_len;       // effective pwm period

  // detect edges once second and third stages agree
  function automatic logic agreed(input logic [2:0] s);
    agreed = (s[1] == s[2]);
  endfunction

  // pin synchronisers and filtered levels
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ext_sync <= 3'h0;
      tp_sync  <= 3'h0;
      ext_lvl  <= 1'b0;
      tp_lvl   <= 1'b0;
    end else begin
      ext_sync <= {ext_sync[1:0], external_clock_input_pin_i};
      tp_sync  <= {tp_sync[1:0], timer_output_pin_i};
      if (agreed(ext_sync)) begin
        ext_lvl <= ext_sync[2];
      end
      if (agreed(tp_sync)) begin
        tp_lvl <= tp_sync[2];
      end
    end
  end

  assign ext_rise = agreed(ext_sync) && ext_sync[2] && !ext_lvl;
  assign ext_fall = agreed(ext_sync) && !ext_sync[2] && ext_lvl;
  assign tp_rise  = agreed(tp_sync) && tp_sync[2] && !tp_lvl;
  assign tp_fall  = agreed(tp_sync) && !tp_sync[2] && tp_lvl;

  // free running prescaler for internal divisions
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      presc <= 6'h00;
    end else begin
      presc <= presc + 6'h01;
    end
  end

  // count clock selection
  always_comb begin
    case (ctrl0.clock_select_field)
      `PTMR_CK_SYS4:  tick = ((presc & `PTMR_DIV4_MASK) == 6'h00);
      `PTMR_CK_SYS:   tick = 1'b1;
      `PTMR_CK_H16:   tick = ((presc & `PTMR_DIV16_MASK) == 6'h00);
      `PTMR_CK_H64:   tick = ((presc & `PTMR_DIV64_MASK) == 6'h00);
      `PTMR_CK_TBC:   tick = tick_tbc_i;
      `PTMR_CK_H:     tick = tick_h_i;
      `PTMR_CK_EXT_R: tick = ext_rise;
      `PTMR_CK_EXT_F: tick = ext_fall;
      default:        tick = 1'b0;
    endcase
  end

  // comparators see the value the counter reaches on this tick, so a clear
  // on a match gives a period of exactly the compare value, not one more
  logic          running;   // counter advancing
  logic [CW-1:0] cnt_next;  // counter value after this tick
  assign running  = ctrl0.counter_enable_bit && !ctrl0.pause_bit && tick;
  assign cnt_next = count + 10'h001;
  assign match_a  = running && (cnt_next == duty);
  assign match_p  = running && (cnt_next == period);
  assign ovf     = running && (count == `PTMR_CNT_MAX);
  assign en_rise = ctrl0.counter_enable_bit && !en_q;

  // clear source selection per mode
  always_comb begin
    clr_cnt = 1'b0;
    set_a   = match_a;
    set_p   = match_p;
    case (ctrl1.mode_field)
      PTMR_MODE_CMP, PTMR_MODE_TMR: begin
        if (ctrl1.clear_select_bit) begin
          clr_cnt = match_a;
          set_p   = 1'b0;
        end else begin
          clr_cnt = match_p || (ovf && (period == `PTMR_CNT_ZERO));
        end
      end
      PTMR_MODE_PWM: begin
        // clear select ignored here
        clr_cnt = match_p || (ovf && (period == `PTMR_CNT_ZERO));
        if (ctrl1.output_action == 2'h3) begin
          clr_cnt = 1'b0; // single pulse keeps counting
          set_p   = 1'b0;
        end
      end
      PTMR_MODE_CAP: begin
        clr_cnt = match_p || (ovf && (period == `PTMR_CNT_ZERO));
      end
      default: clr_cnt = 1'b0;
    endcase
  end

  // capture edge from selected source
  logic src_rise;  // chosen pin rising
  logic src_fall;  // chosen pin falling
  assign src_rise = ctrl1.capture_source_select ? ext_rise : tp_rise;
  assign src_fall = ctrl1.capture_source_select ? ext_fall : tp_fall;
  always_comb begin
    case (ctrl1.output_action)
      2'h0:    cap_ev = src_rise;
      2'h1:    cap_ev = src_fall;
      2'h2:    cap_ev = src_rise || src_fall;
      default: cap_ev = 1'b0;
    endcase
    if (ctrl1.mode_field != PTMR_MODE_CAP || !ctrl0.counter_enable_bit) begin
      cap_ev = 1'b0;
    end
  end

  // single pulse start and stop conditions
  logic sp_mode;  // single pulse selected
  assign sp_mode = (ctrl1.mode_field == PTMR_MODE_PWM) && (ctrl1.output_action == 2'h3);
  assign sp_trig = sp_mode && !ctrl0.counter_enable_bit && ext_rise;
  assign sp_stop = sp_mode && match_a;

  // counter register
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count <= `PTMR_CNT_ZERO;
      en_q  <= 1'b0;
    end else begin
      en_q <= ctrl0.counter_enable_bit;
      if (en_rise) begin
        count <= `PTMR_CNT_ZERO;
      end else if (clr_cnt) begin
        count <= `PTMR_CNT_ZERO;
      end else if (running) begin
        count <= count + 10'h001;
      end
    end
  end

  // single pulse state machine
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sp_state <= PTMR_SP_IDLE;
    end else begin
      case (sp_state)
        PTMR_SP_IDLE: begin
          if (sp_mode && en_rise) begin
            sp_state <= PTMR_SP_RUN;
          end
        end
        PTMR_SP_RUN: begin
          if (!sp_mode || sp_stop || !ctrl0.counter_enable_bit) begin
            sp_state <= PTMR_SP_IDLE;
          end
        end
        default: sp_state <= PTMR_SP_IDLE;
      endcase
    end
  end

  // compare output level
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cmp_out <= 1'b0;
    end else if (en_rise) begin
      cmp_out <= ctrl1.initial_level_bit;
    end else if (match_a && ctrl1.mode_field == PTMR_MODE_CMP) begin
      case (ctrl1.output_action)
        2'h0:    cmp_out <= cmp_out;
        2'h1:    cmp_out <= 1'b0;
        2'h2:    cmp_out <= 1'b1;
        default: cmp_out <= !cmp_out;
      endcase
    end
  end

  // pwm active phase, full duty when duty reaches period
  assign per_len = (period == `PTMR_CNT_ZERO) ? {1'b1, `PTMR_CNT_ZERO} : {1'b0, period};
  assign pwm_raw = ({1'b0, duty} >= per_len) || (count < duty);

  // output selection before polarity
  always_comb begin
    out_act = cmp_out;
    if (ctrl1.mode_field == PTMR_MODE_PWM) begin
      case (ctrl1.output_action)
        2'h0:    out_act = !ctrl1.initial_level_bit;
        2'h1:    out_act = ctrl1.initial_level_bit;
        2'h2:    out_act = pwm_raw ? ctrl1.initial_level_bit : !ctrl1.initial_level_bit;
        default: out_act = (sp_state == PTMR_SP_RUN) ? ctrl1.initial_level_bit
                                                     : !ctrl1.initial_level_bit;
      endcase
    end
  end

  // output pin register, not driven in timer or capture mode
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      timer_output_pin_o    <= 1'b0;
      timer_output_pin_oe_o <= 1'b0;
    end else begin
      timer_output_pin_o    <= out_act ^ ctrl1.output_polarity_bit;
      timer_output_pin_oe_o <= (ctrl1.mode_field == PTMR_MODE_CMP) ||
                               (ctrl1.mode_field == PTMR_MODE_PWM);
    end
  end

  // sticky match flags, set wins over clear
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flag_a <= 1'b0;
      flag_p <= 1'b0;
    end else begin
      if (set_a || cap_ev) begin
        flag_a <= 1'b1;
      end else if (do_write && aw_addr == `PTMR_ADDR_FLAGS && w_strb[0]
                   && w_data[`PTMR_FLAG_A]) begin
        flag_a <= 1'b0;
      end
      if (set_p) begin
        flag_p <= 1'b1;
      end else if (do_write && aw_addr == `PTMR_ADDR_FLAGS && w_strb[0]
                   && w_data[`PTMR_FLAG_P]) begin
        flag_p <= 1'b0;
      end
    end
  end

  // axi write channel capture
  assign s_axi_awready_o = !aw_hold && !s_axi_bvalid_o;
  assign s_axi_wready_o  = !w_hold && !s_axi_bvalid_o;
  assign do_write        = aw_hold && w_hold && !s_axi_bvalid_o;
  assign wr_ctrl0        = do_write && aw_addr == `PTMR_ADDR_CTRL0 && w_strb[0];
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      aw_hold        <= 1'b0;
      w_hold         <= 1'b0;
      aw_addr        <= 8'h00;
      w_data         <= 32'h0000_0000;
      w_strb         <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= `PTMR_RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
      end
      if (do_write) begin
        aw_hold        <= 1'b0;
        w_hold         <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        case (aw_addr)
          `PTMR_ADDR_CTRL0, `PTMR_ADDR_CTRL1, `PTMR_ADDR_CNT_LO,
          `PTMR_ADDR_CNT_HI, `PTMR_ADDR_DUTY_LO, `PTMR_ADDR_DUTY_HI,
          `PTMR_ADDR_PER_LO, `PTMR_ADDR_PER_HI, `PTMR_ADDR_FLAGS:
            s_axi_bresp_o <= `PTMR_RESP_OKAY;
          default: s_axi_bresp_o <= `PTMR_RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  // software registers; a single pulse trigger or stop moves the enable
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl0  <= '0;
      ctrl1  <= '0;
      duty   <= `PTMR_CNT_ZERO;
      period <= `PTMR_CNT_ZERO;
    end else begin
      if (wr_ctrl0) begin
        ctrl0 <= w_data[7:3];
      end
      if (sp_trig) begin
        ctrl0.counter_enable_bit <= 1'b1;
      end else if (sp_stop) begin
        ctrl0.counter_enable_bit <= 1'b0;
      end
      if (do_write && w_strb[0]) begin
        case (aw_addr)
          `PTMR_ADDR_CTRL1:   ctrl1 <= w_data[7:0];
          `PTMR_ADDR_DUTY_LO: duty[7:0] <= w_data[7:0];
          `PTMR_ADDR_DUTY_HI: duty[CW-1:8] <= w_data[CW-9:0];
          `PTMR_ADDR_PER_LO:  period[7:0] <= w_data[7:0];
          `PTMR_ADDR_PER_HI:  period[CW-1:8] <= w_data[CW-9:0];
          default: ;
        endcase
      end
      if (cap_ev) begin
        duty <= count; // capture into duty value
      end
    end
  end

  // read data multiplexer
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rerr  = 1'b0;
    case (s_axi_araddr_i)
      `PTMR_ADDR_CTRL0:   next_rdata[7:3] = ctrl0;
      `PTMR_ADDR_CTRL1:   next_rdata[7:0] = ctrl1;
      `PTMR_ADDR_CNT_LO:  next_rdata[7:0] = count[7:0];
      `PTMR_ADDR_CNT_HI:  next_rdata[1:0] = count[CW-1:8];
      `PTMR_ADDR_DUTY_LO: next_rdata[7:0] = duty[7:0];
      `PTMR_ADDR_DUTY_HI: next_rdata[1:0] = duty[CW-1:8];
      `PTMR_ADDR_PER_LO:  next_rdata[7:0] = period[7:0];
      `PTMR_ADDR_PER_HI:  next_rdata[1:0] = period[CW-1:8];
      `PTMR_ADDR_FLAGS:   next_rdata[1:0] = {flag_p, flag_a};
      default:            next_rerr = 1'b1;
    endcase
  end

  // axi read channel
  assign s_axi_arready_o = !s_axi_rvalid_o;
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= 32'h0000_0000;
      s_axi_rresp_o  <= `PTMR_RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o  <= next_rdata;
      s_axi_rresp_o  <= next_rerr ? `PTMR_RESP_SLVERR : `PTMR_RESP_OKAY;
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end
endmodule

//--- test/ptmr_timer_properties.sv
`timescale 1ns/1ps
// watches the register bus of the timer
module ptmr_timer_properties (
  input wire logic        core_clk_i,
  input wire logic        reset_n_i,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic [1:0]  s_axi_bresp_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic [7:0]  s_axi_araddr_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0]  s_axi_rresp_o,
  input wire logic        s_axi_rvalid_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  // address and data taken together
  sequence s_wr_take;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  // read address taken
  sequence s_rd_take;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence
  property p_wr_ans;
    s_wr_take |-> ##2 s_axi_bvalid_o;
  endproperty
  property p_b_hold;
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
  endproperty
  property p_w_refuse;
    s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o;
  endproperty
  property p_r_ans;
    s_rd_take |=> s_axi_rvalid_o;
  endproperty
  property p_ar_refuse;
    s_axi_rvalid_o |-> !s_axi_arready_o;
  endproperty
  property p_unmap;
    s_rd_take ##0 (s_axi_araddr_i > 8'h20) |=> s_axi_rresp_o == 2'h2 && s_axi_rdata_o == 0;
  endproperty
  property p_hi_zero;
    s_rd_take ##0 (s_axi_araddr_i[3:0] == 4'hC) |=> s_axi_rdata_o[31:2] == 0;
  endproperty
  property p_lo_byte;
    s_rd_take ##0 (s_axi_araddr_i < 8'h20) |=> s_axi_rdata_o[31:8] == 0 && s_axi_rresp_o == 0;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write response late");
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  a_w_refuse: assert property (p_w_refuse) else $error("write taken while busy");
  a_r_ans: assert property (p_r_ans) else $error("read data late");
  a_ar_refuse: assert property (p_ar_refuse) else $error("read taken while busy");
  a_unmap: assert property (p_unmap) else $error("unmapped read answered");
  a_hi_zero: assert property (p_hi_zero) else $error("high register upper bits set");
  a_lo_byte: assert property (p_lo_byte) else $error("register wider than a byte");
endmodule

bind ptmr_timer ptmr_timer_properties ptmr_timer_properties_i (
  .core_clk_i(core_clk_i),
  .reset_n_i(reset_n_i),
  .s_axi_awvalid_i(s_axi_awvalid_i),
  .s_axi_awready_o(s_axi_awready_o),
  .s_axi_wvalid_i(s_axi_wvalid_i),
  .s_axi_wready_o(s_axi_wready_o),
  .s_axi_bresp_o(s_axi_bresp_o),
  .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i),
  .s_axi_araddr_i(s_axi_araddr_i),
  .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o),
  .s_axi_rdata_o(s_axi_rdata_o),
  .s_axi_rresp_o(s_axi_rresp_o),
  .s_axi_rvalid_o(s_axi_rvalid_o)
);

//--- test/ptmr_pin_model.sv
`timescale 1ns/1ps
// far side: trigger pin and output pin wire
module ptmr_pin_model (
  input  wire logic ext_level_i,
  input  wire logic pin_o_i,
  input  wire logic pin_oe_i,
  output logic      ext_pin_o,
  output logic      pin_rb_o
);
  // released pin has no pull: it reads the inverse of the last level
  assign ext_pin_o = ext_level_i;
  assign pin_rb_o  = pin_oe_i ? pin_o_i : ~pin_o_i;
endmodule

//--- test/ptmr_timer_tb.sv
`timescale 1ns/1ps
module ptmr_timer_tb;
  logic        clk, rst_n, awv, wv, bready, arv, rready, ext_lvl;
  logic        th = 1'b0;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rd, v;
  logic [1:0]  rsp;
  wire         awr, wr_rdy, bv, arr, rv, pin_rb, ext_pin, pin, oe;
  wire  [1:0]  br, rr;
  wire  [31:0] rdat;
  int          n_errors, n_checks, i, k;
  // compare mode settings and pin level after a match
  logic [7:0]  cm [6] = '{8'h18, 8'h08, 8'h10, 8'h38, 8'h24, 8'h20};
  logic        cx [6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
  // pwm mode settings and steady pin level
  logic [7:0]  pm [7] = '{8'hA8, 8'hAC, 8'h98, 8'h9C, 8'h88, 8'h90, 8'hB8};
  logic        px [7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};

  ptmr_timer ptmr_timer_i (.core_clk_i(clk), .reset_n_i(rst_n), .s_axi_awaddr_i(awa),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF),
    .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_rdy), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv),
    .s_axi_bready_i(bready), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arr), .s_axi_rdata_o(rdat), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv),
    .s_axi_rready_i(rready), .tick_tbc_i(1'b0), .tick_h_i(th),
    .external_clock_input_pin_i(ext_pin), .timer_output_pin_i(pin_rb),
    .timer_output_pin_o(pin), .timer_output_pin_oe_o(oe));
  ptmr_pin_model ptmr_pin_model_i (.ext_level_i(ext_lvl), .pin_o_i(pin),
    .pin_oe_i(oe), .ext_pin_o(ext_pin), .pin_rb_o(pin_rb));

  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  // spare tick source
  always @(posedge clk) th <= ~th;

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %s expected %0h seen %0h", nm, e, s);
    end
  endtask
  // bound on every wait
  task automatic guard(inout int n);
    n++;
    if (n > 2000) begin
      n_errors++;
      tally_and_finish();
    end
  endtask
  // settle at a falling edge after some cycles
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw;
    int n;
    ta = 0;
    tw = 0;
    n = 0;
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    bready <= 1;
    while (!(ta && tw)) begin
      @(negedge clk);
      ta = ta | awr;
      tw = tw | wr_rdy;
      guard(n);
      @(posedge clk);
      if (ta) awv <= 0;
      if (tw) wv <= 0;
    end
    do begin
      @(negedge clk);
      guard(n);
    end while (!bv);
    rsp = br;
    @(posedge clk);
    bready <= 0;
  endtask
  task automatic rd_(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clk);
    ara <= a;
    arv <= 1;
    rready <= 1;
    do begin
      @(negedge clk);
      guard(n);
    end while (!arr);
    @(posedge clk);
    arv <= 0;
    do begin
      @(negedge clk);
      guard(n);
    end while (!rv);
    rd = rdat;
    rsp = rr;
    @(posedge clk);
    rready <= 0;
  endtask

  initial begin
    {rst_n, awv, wv, bready, arv, rready, ext_lvl} = 0;
    {awa, ara, wd} = 0;
    n_errors = 0;
    n_checks = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1;
    // reset values of every register
    for (i = 0; i < 9; i++) begin
      rd_(8'(i * 4));
      chk("reset value", rd, 0);
    end
    rd_(8'h24);
    chk("unmapped response", rsp, 2);
    for (i = 0; i < 2; i++) begin
      wr(8'(8'h14 + i * 8), 32'hFF);
      chk("write response", rsp, 0);
      rd_(8'(8'h14 + i * 8));
      chk("compare high bits", rd, 3);
    end
    // compare mode, duty 5 period 10, slow count clock
    wr(8'h10, 5);
    wr(8'h14, 0);
    wr(8'h18, 10);
    wr(8'h1C, 0);
    for (i = 0; i < 6; i++) begin
      wr(8'h00, 8'h30);
      wr(8'h20, 3);
      wr(8'h04, cm[i]);
      wr(8'h00, 8'h38);
      cyc(10);
      chk("pin initial", pin, cm[i][3] ^ cm[i][2]);
      chk("output enable", oe, 1);
      cyc(500);
      chk("pin after match", pin, cx[i]);
    end
    cyc(300);
    rd_(8'h20);
    chk("compare flags", rd, 3);
    // pause freezes, resume moves on
    wr(8'h00, 8'hB8);
    rd_(8'h08);
    v = rd;
    cyc(200);
    rd_(8'h08);
    chk("paused count", rd, v);
    wr(8'h00, 8'h38);
    cyc(200);
    rd_(8'h08);
    chk("resumed count", rd != v, 1);
    wr(8'h00, 8'h30);
    rd_(8'h08);
    v = rd;
    cyc(200);
    rd_(8'h08);
    chk("stopped count", rd, v);
    // timer mode: clear on a, then clear on p
    wr(8'h10, 8);
    wr(8'h18, 3);
    for (i = 0; i < 2; i++) begin
      wr(8'h00, 8'h10);
      wr(8'h20, 3);
      wr(8'h04, 8'hC1 - i);
      wr(8'h00, 8'h18);
      cyc(200);
      rd_(8'h20);
      chk("timer flags", rd, 1 + i);
      rd_(8'h08);
      chk("count bound", rd <= (i ? 3 : 8), 1);
      chk("timer pin released", oe, 0);
    end
    // pwm: duty 2 of period 4 gives half high
    wr(8'h10, 2);
    wr(8'h18, 4);
    wr(8'h00, 8'h10);
    wr(8'h04, 8'hA8);
    wr(8'h00, 8'h18);
    cyc(20);
    k = 0;
    repeat (400) begin
      @(negedge clk);
      k += pin;
    end
    chk("pwm high cycles", k, 200);
    wr(8'h20, 3);
    cyc(10);
    rd_(8'h20);
    chk("pwm flags", rd, 3);
    // duty at period: full, forced, polarity, single pulse
    wr(8'h10, 4);
    for (i = 0; i < 7; i++) begin
      wr(8'h00, 8'h10);
      wr(8'h04, pm[i]);
      wr(8'h00, 8'h18);
      cyc(10);
      k = 0;
      repeat (40) begin
        @(negedge clk);
        k += pin;
      end
      chk("pwm steady level", k, px[i] ? 40 : 0);
    end
    rd_(8'h00);
    chk("pulse ends enable", rd, 8'h10);
    // capture from the clock pin, every edge code, then output pin as source
    wr(8'h18, 0);
    for (i = 0; i < 5; i++) begin
      wr(8'h00, 8'h10);
      wr(8'h04, (i < 4) ? 8'h42 | (i << 4) : 8'h40);
      wr(8'h10, 8'hFF); // keeps comparator a out of the window
      wr(8'h00, 8'h18);
      for (k = 0; k < 2; k++) begin
        wr(8'h20, 3);
        cyc(20);
        @(posedge clk);
        ext_lvl <= ~ext_lvl;
        cyc(20);
        rd_(8'h20);
        chk("capture flag", rd[0], i == 2 || i == k);
      end
    end
    // count clock from rising edges of the clock pin
    wr(8'h00, 8'h10);
    wr(8'h04, 8'hC0);
    wr(8'h00, 8'h68);
    repeat (6) begin
      @(posedge clk);
      ext_lvl <= ~ext_lvl;
      cyc(10);
    end
    rd_(8'h08);
    chk("pin edge count", rd, 3);
    tally_and_finish();
  end
endmodule
